// *** adc_seq_pkg.sv ***
// package: register map, fields and timing for the adc sequencer
package adc_seq_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CFG       = 8'h00;
  localparam logic [7:0] OFF_TRIGGER   = 8'h04;
  localparam logic [7:0] OFF_STATUS    = 8'h08;
  localparam logic [7:0] OFF_FIFO      = 8'h0c;
  localparam logic [7:0] OFF_FLAGS     = 8'h10;
  localparam logic [7:0] OFF_WINDOW    = 8'h14;
  localparam logic [7:0] OFF_SLOT_BASE = 8'h20;
  localparam logic [7:0] SLOT_MASK     = 8'he3;
  localparam int SLOT_IDX_LSB = 2;
  localparam int SLOT_IDX_W   = 3;
  localparam int NUM_SLOTS    = 8;
  // config register fields
  localparam int CFG_W        = 9;
  localparam int CFG_EN       = 0;
  localparam int CFG_CLOCK_SOURCE_SELECT   = 1;
  localparam int CFG_KEEP_OSC = 3;
  localparam int CFG_SCAN     = 4;
  localparam int CFG_REPEAT   = 5;
  localparam int CFG_PREC     = 6;
  localparam int CFG_DMA_EN   = 8;
  localparam logic [CFG_W-1:0] CFG_RESET = 9'h000;
  // slot register fields
  localparam int SLOT_W     = 15;
  localparam int SL_EN      = 0;
  localparam int SL_CHAN    = 1;
  localparam int SL_TRACK   = 5;
  localparam int SL_AVG     = 12;
  localparam int SL_WIN     = 14;
  localparam logic [SLOT_W-1:0] SLOT_RESET = 15'h0000;
  // clock source select codes
  localparam logic [1:0] CLK_FAST_48  = 2'h0;
  localparam logic [1:0] CLK_INV_48   = 2'h1;
  localparam logic [1:0] CLK_FAST_24  = 2'h2;
  localparam logic [1:0] CLK_SECOND_48 = 2'h3;
  // precision codes and base latency cycles
  localparam logic [1:0] PREC_12 = 2'h0;
  localparam logic [1:0] PREC_10 = 2'h1;
  localparam logic [1:0] PREC_8  = 2'h2;
  localparam logic [6:0] BASE_12 = 7'h13;
  localparam logic [6:0] BASE_10 = 7'h0f;
  localparam logic [6:0] BASE_8  = 7'h0c;
  localparam logic [11:0] FS_12 = 12'hfff;
  localparam logic [11:0] FS_10 = 12'h3ff;
  localparam logic [11:0] FS_8  = 12'h0ff;
  // tracking cycles = field + minimum, field clamped
  localparam logic [6:0] TRACK_MIN       = 7'h05;
  localparam logic [6:0] TRACK_FIELD_MAX = 7'h40;
  // mux channel codes
  localparam logic [3:0] CH_TEMP    = 4'hc;
  localparam logic [3:0] CH_VSS     = 4'he;
  localparam logic [3:0] CH_DIVIDER = 4'hf;
  // result queue
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_AW    = 4;
  localparam int FIFO_DW    = 16;
  localparam logic [4:0] ALMOST_FULL = 5'h0c;
  // flag bits
  localparam int FLAGS_W    = 7;
  localparam int FL_FULL    = 0;
  localparam int FL_AFULL   = 1;
  localparam int FL_SCAN    = 2;
  localparam int FL_CONV    = 3;
  localparam int FL_WIN_IN  = 4;
  localparam int FL_WIN_OUT = 5;
  localparam int FL_DMA     = 6;
  // sequencer states
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_REQ   = 2'b01,
    ST_START = 2'b10,
    ST_WAIT  = 2'b11
  } seq_state_e;
endpackage

// *** result_fifo.sv ***
// result queue: flip-flop storage, sixteen entries
`timescale 1ns/1ps
module result_fifo
  import adc_seq_pkg::*;
(
  input  wire logic               clock,  // system clock
  input  wire logic               rst_n,  // async reset, active low
  input  wire logic               push,   // write one entry
  input  wire logic [FIFO_DW-1:0] din,    // entry to write
  input  wire logic               pop,    // drop oldest entry
  output logic      [FIFO_DW-1:0] dout,   // oldest entry
  output logic      [FIFO_AW:0]   count,  // occupancy
  output logic                    full,   // no room
  output logic                    empty   // nothing stored
);
  logic [FIFO_DW-1:0] mem_r   [FIFO_DEPTH];  // storage
  logic [FIFO_DW-1:0] mem_nxt [FIFO_DEPTH];
  logic [FIFO_AW-1:0] wr_r, wr_nxt;          // write index
  logic [FIFO_AW-1:0] rd_r, rd_nxt;          // read index
  logic [FIFO_AW:0]   cnt_r, cnt_nxt;        // occupancy
  logic               do_push, do_pop;

  // pointers and count
  always_comb begin
    do_push = push && (cnt_r != FIFO_AW'(0) + (FIFO_AW+1)'(FIFO_DEPTH));
    do_pop  = pop && (cnt_r != '0);
    wr_nxt  = do_push ? wr_r + 1'b1 : wr_r;
    rd_nxt  = do_pop ? rd_r + 1'b1 : rd_r;
    cnt_nxt = cnt_r + (FIFO_AW+1)'(do_push) - (FIFO_AW+1)'(do_pop);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else begin
      wr_r  <= wr_nxt;
      rd_r  <= rd_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // one storage word per entry
  genvar i;
  generate
    for (i = 0; i < FIFO_DEPTH; i++) begin : g_ent
      always_comb begin
        mem_nxt[i] = (do_push && wr_r == FIFO_AW'(i)) ? din : mem_r[i];
      end
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          mem_r[i] <= '0;
        end else begin
          mem_r[i] <= mem_nxt[i];
        end
      end
    end
  endgenerate

  assign dout  = mem_r[rd_r];
  assign count = cnt_r;
  assign full  = (cnt_r == (FIFO_AW+1)'(FIFO_DEPTH));
  assign empty = (cnt_r == '0);
endmodule

// *** window_cmp.sv ***
// window comparator: flags entry into and exit from the threshold band
`timescale 1ns/1ps
module window_cmp
  import adc_seq_pkg::*;
(
  input  wire logic        clock,     // system clock
  input  wire logic        rst_n,     // async reset, active low
  input  wire logic        valid,     // new result present
  input  wire logic [11:0] value,     // result value
  input  wire logic [11:0] lower,     // lower threshold
  input  wire logic [11:0] upper,     // upper threshold
  output logic             incursion, // moved into band
  output logic             excursion  // moved out of band
);
  logic inside_r, inside_nxt;  // last seen position
  logic inside_now;

  // compare and detect changes
  always_comb begin
    inside_now = (value >= lower) && (value <= upper);
    inside_nxt = valid ? inside_now : inside_r;
    incursion  = valid && inside_now && !inside_r;
    excursion  = valid && !inside_now && inside_r;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      inside_r <= 1'b0;
    end else begin
      inside_r <= inside_nxt;
    end
  end
endmodule

// *** sar_adc_sequencer.sv ***
// sar adc sequencer: slots, clock request, timing, result queue, bus slave
//
// Functional notes
// - eight slots, active ones done in order
// - every slot result enters 16-deep queue
// - request clock while enabled and scanning
// - release or keep oscillator between scans
// - four clock sources, fast 48 default
// - sample after tracking plus base cycles
// - tracking cycles from five to sixty-nine
// - base latency 19, 15, 12 by precision
// - over-reference input returns full scale code
// - divider on only when scanning channel 15 (here on during every conversion while any active slot selects channel 15)
// - battery load follows external enable bit
// - eleven channels: eight pins, ground, divider, temp
// - single, repeat single, scan, repeat scan
// - tracking time set per slot
// - flags for queue, scan, conversion, window, dma
// - window compare detects entry and exit
// - accumulate and scale successive slot samples
//
// Our own choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module sar_adc_sequencer
  import adc_seq_pkg::*;
(
  input  wire logic        clock,               // 40 MHz system clock
  input  wire logic        rst_n,               // async reset, active low
  input  wire logic [7:0]  address,             // avalon byte address
  input  wire logic        read,                // avalon read
  input  wire logic        write,               // avalon write
  input  wire logic [31:0] writedata,           // avalon write data
  output logic      [31:0] readdata,            // avalon read data
  output logic             waitrequest,         // avalon wait
  input  wire logic        trigger_in,          // hardware trigger pulse
  input  wire logic        clock_ack,           // clock generator grant
  input  wire logic [11:0] conv_data,           // core result
  input  wire logic        conv_over,           // input above reference
  input  wire logic        battery_load_enable, // from control block
  input  wire logic        dma_ack,             // dma took head entry
  output logic             clock_request,       // oscillator request
  output logic [1:0]       clock_source_select, // converter clock choice
  output logic             conv_start,          // start tracking pulse
  output logic [3:0]       conv_channel,        // mux channel
  output logic [1:0]       conv_precision,      // precision mode
  output logic             divider_enable,      // supply divider on
  output logic             battery_load,        // load resistor on
  output logic             dma_request          // queue has data for dma
);
  // bus side state
  logic                 wait_r, wait_nxt;         // waitrequest
  logic [31:0]          rdata_r, rdata_nxt;       // read data
  logic [CFG_W-1:0]     cfg_r, cfg_nxt;           // configuration
  logic [11:0]          win_lo_r, win_lo_nxt;     // lower threshold
  logic [11:0]          win_hi_r, win_hi_nxt;     // upper threshold
  logic [FLAGS_W-1:0]   flags_r, flags_nxt;       // sticky flags
  logic                 trig_r, trig_nxt;         // pending trigger
  logic [SLOT_W-1:0]    slot_r   [NUM_SLOTS];     // slot configs
  logic [SLOT_W-1:0]    slot_nxt [NUM_SLOTS];
  // sequencer state
  seq_state_e           state_r, state_nxt;       // fsm
  logic [2:0]           idx_r, idx_nxt;           // current slot
  logic [6:0]           lat_r, lat_nxt;           // latency countdown
  logic [14:0]          acc_r, acc_nxt;           // accumulator
  logic [2:0]           acc_n_r, acc_n_nxt;       // samples summed
  logic                 start_r, start_nxt;       // conv_start
  logic [3:0]           chan_r, chan_nxt;         // conv_channel
  logic                 req_r, req_nxt;           // clock_request
  logic                 div_r, div_nxt;           // divider_enable
  logic                 bload_r;                  // battery_load
  logic                 dreq_r;                   // dma_request
  logic [1:0]           csel_r;                   // clock select out
  logic [1:0]           prec_r;                   // precision out
  // helpers
  logic                 wr_go, rd_go, slot_hit;
  logic [SLOT_IDX_W-1:0] sidx;
  logic                 pop_sw, push;
  logic [FIFO_DW-1:0]   push_data, head;
  logic [FIFO_AW:0]     fcount;
  logic                 ffull, fempty;
  logic                 win_in, win_out, win_valid;
  logic [11:0]          result;
  logic [NUM_SLOTS-1:0] active;
  logic                 scan_done, conv_done, div_need;
  logic [3:0]           nxt_from_idx, first_act;
  logic [SLOT_W-1:0]    cur;
  logic [6:0]           track, base;
  logic [11:0]          sample, fs;
  logic [14:0]          sum;

  // find next active slot at or after start
  function automatic logic [3:0] find_act(input logic [NUM_SLOTS-1:0] m,
                                          input logic [3:0] from);
    logic [3:0] r;
    r = 4'h0;
    for (int k = NUM_SLOTS - 1; k >= 0; k--) begin
      if (m[k] && 4'(k) >= from) begin
        r = {1'b1, 3'(k)};
      end
    end
    return r;
  endfunction

  // bus decode; write lands on the edge that sees waitrequest low
  always_comb begin
    wr_go    = write && !wait_r;
    rd_go    = read && !wait_r;
    slot_hit = (address & SLOT_MASK) == OFF_SLOT_BASE;
    sidx     = address[SLOT_IDX_LSB +: SLOT_IDX_W];
    pop_sw   = rd_go && address == OFF_FIFO;
  end

  // bus slave and registers: next values
  always_comb begin
    wait_nxt   = !((read || write) && wait_r);
    rdata_nxt  = rdata_r;
    cfg_nxt    = cfg_r;
    win_lo_nxt = win_lo_r;
    win_hi_nxt = win_hi_r;
    trig_nxt   = trig_r || trigger_in;
    if (read && wait_r) begin
      rdata_nxt = 32'h0000_0000;  // unmapped reads as zero
      if (address == OFF_CFG) begin
        rdata_nxt = 32'(cfg_r);
      end else if (address == OFF_STATUS) begin
        rdata_nxt = {24'h00_0000, req_r, state_r != ST_IDLE, 1'b0, fcount};
      end else if (address == OFF_FIFO) begin
        rdata_nxt = {11'h000, fcount, head};
      end else if (address == OFF_FLAGS) begin
        rdata_nxt = 32'(flags_r);
      end else if (address == OFF_WINDOW) begin
        rdata_nxt = {4'h0, win_hi_r, 4'h0, win_lo_r};
      end else if (slot_hit) begin
        rdata_nxt = 32'(slot_r[sidx]);
      end
    end
    if (wr_go) begin
      if (address == OFF_CFG) begin
        cfg_nxt = writedata[CFG_W-1:0];
      end else if (address == OFF_TRIGGER && writedata[0]) begin
        trig_nxt = 1'b1;
      end else if (address == OFF_WINDOW) begin
        win_lo_nxt = writedata[11:0];
        win_hi_nxt = writedata[27:16];
      end
    end
    if (state_r == ST_IDLE && state_nxt != ST_IDLE) begin
      trig_nxt = 1'b0;  // trigger consumed by a scan
    end
    // flags: set beats write-one-to-clear
    flags_nxt = flags_r;
    if (wr_go && address == OFF_FLAGS) begin
      flags_nxt = flags_r & ~writedata[FLAGS_W-1:0];
    end
    flags_nxt[FL_FULL]    = flags_nxt[FL_FULL] | (push && fcount == 5'(FIFO_DEPTH - 1));
    flags_nxt[FL_AFULL]   = flags_nxt[FL_AFULL] | (push && fcount == ALMOST_FULL - 5'h01);
    flags_nxt[FL_SCAN]    = flags_nxt[FL_SCAN] | scan_done;
    flags_nxt[FL_CONV]    = flags_nxt[FL_CONV] | conv_done;
    flags_nxt[FL_WIN_IN]  = flags_nxt[FL_WIN_IN] | win_in;
    flags_nxt[FL_WIN_OUT] = flags_nxt[FL_WIN_OUT] | win_out;
    flags_nxt[FL_DMA]     = flags_nxt[FL_DMA] | (dma_ack && fcount == 5'h01 && !push);
  end

  // bus and config registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wait_r   <= 1'b1;
      rdata_r  <= 32'h0000_0000;
      cfg_r    <= CFG_RESET;
      win_lo_r <= 12'h000;
      win_hi_r <= 12'h000;
      flags_r  <= '0;
      trig_r   <= 1'b0;
    end else begin
      wait_r   <= wait_nxt;
      rdata_r  <= rdata_nxt;
      cfg_r    <= cfg_nxt;
      win_lo_r <= win_lo_nxt;
      win_hi_r <= win_hi_nxt;
      flags_r  <= flags_nxt;
      trig_r   <= trig_nxt;
    end
  end

  // per-slot configuration registers
  genvar s;
  generate
    for (s = 0; s < NUM_SLOTS; s++) begin : g_slot
      always_comb begin
        slot_nxt[s] = slot_r[s];
        if (wr_go && slot_hit && sidx == SLOT_IDX_W'(s)) begin
          slot_nxt[s] = writedata[SLOT_W-1:0];
        end
      end
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          slot_r[s] <= SLOT_RESET;
        end else begin
          slot_r[s] <= slot_nxt[s];
        end
      end
      assign active[s] = slot_r[s][SL_EN];
    end
  endgenerate

  // timing and sample shaping for the current slot
  always_comb begin
    cur   = slot_r[idx_r];
    track = (cur[SL_TRACK +: 7] > TRACK_FIELD_MAX ? TRACK_FIELD_MAX
             : cur[SL_TRACK +: 7]) + TRACK_MIN;
    unique case (cfg_r[CFG_PREC +: 2])
      PREC_10: begin base = BASE_10; fs = FS_10; end
      PREC_8:  begin base = BASE_8;  fs = FS_8;  end
      default: begin base = BASE_12; fs = FS_12; end
    endcase
    sample = conv_over ? fs : (conv_data & fs);
    sum    = acc_r + 15'(sample);
    result = 12'(sum >> cur[SL_AVG +: 2]);
    nxt_from_idx = find_act(active, 4'(idx_r) + 4'h1);
    first_act    = find_act(active, 4'h0);
    div_need     = 1'b0;
    for (int k = 0; k < NUM_SLOTS; k++) begin
      div_need = div_need | (active[k] && slot_r[k][SL_CHAN +: 4] == CH_DIVIDER);
    end
  end

  // sequencer fsm: next values
  always_comb begin
    state_nxt = state_r;
    idx_nxt   = idx_r;
    lat_nxt   = lat_r;
    acc_nxt   = acc_r;
    acc_n_nxt = acc_n_r;
    start_nxt = 1'b0;
    chan_nxt  = chan_r;
    push      = 1'b0;
    push_data = {1'b0, idx_r, result};
    win_valid = 1'b0;
    scan_done = 1'b0;
    conv_done = 1'b0;
    unique case (state_r)
      ST_IDLE: begin
        if (cfg_r[CFG_EN] && trig_r && first_act[3]) begin
          state_nxt = ST_REQ;
          if (cfg_r[CFG_SCAN] || !active[idx_r]) begin
            idx_nxt = first_act[2:0];  // scan starts at lowest slot
          end
        end
      end
      ST_REQ: begin
        if (!cfg_r[CFG_EN]) begin
          state_nxt = ST_IDLE;
        end else if (clock_ack) begin
          state_nxt = ST_START;
        end
      end
      ST_START: begin
        start_nxt = 1'b1;
        chan_nxt  = cur[SL_CHAN +: 4];
        lat_nxt   = track + base - 7'h01;
        state_nxt = ST_WAIT;
      end
      ST_WAIT: begin
        if (lat_r != 7'h00) begin
          lat_nxt = lat_r - 7'h01;
        end else begin
          acc_nxt   = sum;
          acc_n_nxt = acc_n_r + 3'h1;
          state_nxt = ST_START;  // more samples for this slot
          if (acc_n_r == 3'((4'h1 << cur[SL_AVG +: 2]) - 4'h1)) begin
            push      = 1'b1;
            win_valid = cur[SL_WIN];
            conv_done = 1'b1;
            acc_nxt   = 15'h0000;
            acc_n_nxt = 3'h0;
            if (cfg_r[CFG_SCAN] && nxt_from_idx[3]) begin
              idx_nxt = nxt_from_idx[2:0];
            end else begin
              scan_done = cfg_r[CFG_SCAN];
              idx_nxt   = cfg_r[CFG_SCAN] ? first_act[2:0]
                          : (nxt_from_idx[3] ? nxt_from_idx[2:0] : first_act[2:0]);
              state_nxt = (cfg_r[CFG_REPEAT] && cfg_r[CFG_EN]) ? ST_START : ST_IDLE;
            end
          end
          if (!cfg_r[CFG_EN]) begin
            state_nxt = ST_IDLE;
          end
        end
      end
    endcase
    // request held while busy, or kept between scans when asked
    req_nxt = cfg_r[CFG_EN] && (state_nxt != ST_IDLE || cfg_r[CFG_KEEP_OSC]);
    div_nxt = (state_nxt == ST_START || state_nxt == ST_WAIT) && div_need;
  end

  // sequencer registers and registered outputs
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      idx_r   <= 3'h0;
      lat_r   <= 7'h00;
      acc_r   <= 15'h0000;
      acc_n_r <= 3'h0;
      start_r <= 1'b0;
      chan_r  <= 4'h0;
      req_r   <= 1'b0;
      div_r   <= 1'b0;
      bload_r <= 1'b0;
      dreq_r  <= 1'b0;
      csel_r  <= CLK_FAST_48;
      prec_r  <= PREC_12;
    end else begin
      state_r <= state_nxt;
      idx_r   <= idx_nxt;
      lat_r   <= lat_nxt;
      acc_r   <= acc_nxt;
      acc_n_r <= acc_n_nxt;
      start_r <= start_nxt;
      chan_r  <= chan_nxt;
      req_r   <= req_nxt;
      div_r   <= div_nxt;
      bload_r <= battery_load_enable;
      dreq_r  <= cfg_r[CFG_DMA_EN] && (fcount > 5'h01 || (fcount == 5'h01 && !(dma_ack || pop_sw)));
      csel_r  <= cfg_r[CFG_CLOCK_SOURCE_SELECT +: 2];
      prec_r  <= cfg_r[CFG_PREC +: 2];
    end
  end

  // result queue; bus read or dma ack drops the head
  result_fifo u_fifo (
    .clock (clock),
    .rst_n (rst_n),
    .push  (push),
    .din   (push_data),
    .pop   (pop_sw || dma_ack),
    .dout  (head),
    .count (fcount),
    .full  (ffull),
    .empty (fempty)
  );

  // threshold band watcher on queued results
  window_cmp u_win (
    .clock     (clock),
    .rst_n     (rst_n),
    .valid     (win_valid),
    .value     (result),
    .lower     (win_lo_r),
    .upper     (win_hi_r),
    .incursion (win_in),
    .excursion (win_out)
  );

  assign readdata            = rdata_r;
  assign waitrequest         = wait_r;
  assign clock_request       = req_r;
  assign clock_source_select = csel_r;
  assign conv_start          = start_r;
  assign conv_channel        = chan_r;
  assign conv_precision      = prec_r;
  assign divider_enable      = div_r;
  assign battery_load        = bload_r;
  assign dma_request         = dreq_r;
endmodule

// *** sar_adc_sequencer_chk.sv ***
// checker: bus answer, clock handshake and converter timing
`timescale 1ns/1ps
module sar_adc_sequencer_chk (
  input wire logic        clock,               // clock
  input wire logic        rst_n,               // reset
  input wire logic        read,                // bus read
  input wire logic        write,               // bus write
  input wire logic        waitrequest,         // bus wait
  input wire logic [31:0] readdata,            // bus data
  input wire logic        clock_ack,           // clock grant
  input wire logic        clock_request,       // clock request
  input wire logic        conv_start,          // start pulse
  input wire logic        divider_enable,      // divider on
  input wire logic        battery_load_enable, // load bit
  input wire logic        battery_load         // load out
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic [7:0] gap_r;   // cycles since last start
  logic [7:0] gap_nxt; // next gap
  // saturating count of cycles between starts
  always_comb begin
    gap_nxt = conv_start ? 8'h00 : gap_r + {7'h0, gap_r != 8'hff};
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) gap_r <= 8'hff;
    else gap_r <= gap_nxt;
  end
  sequence s_taken; (read || write) && waitrequest; endsequence
  sequence s_answer; !waitrequest ##1 waitrequest; endsequence
  chk_bus_answer: assert property (s_taken |=> s_answer)
    else $error("bus answer not one cycle");
  chk_wait_idle: assert property (!(read || write) && waitrequest |=> waitrequest)
    else $error("bus answer without request");
  chk_read_hold: assert property (!(read && waitrequest) |=> $stable(readdata))
    else $error("read data moved without read");
  chk_load_follow: assert property (1'b1 |=> battery_load == $past(battery_load_enable))
    else $error("load resistor not following bit");
  chk_start_pulse: assert property (conv_start |=> !conv_start)
    else $error("start pulse too long");
  chk_start_granted: assert property (conv_start |-> clock_request && clock_ack)
    else $error("start without granted clock");
  chk_div_power: assert property ($rose(divider_enable) |-> clock_request)
    else $error("divider on while idle");
  chk_start_spacing: assert property (conv_start |-> gap_r >= 8'h11)
    else $error("samples too close");
endmodule
bind sar_adc_sequencer sar_adc_sequencer_chk u_chk (
  .clock(clock), .rst_n(rst_n), .read(read), .write(write),
  .waitrequest(waitrequest), .readdata(readdata), .clock_ack(clock_ack),
  .clock_request(clock_request), .conv_start(conv_start),
  .divider_enable(divider_enable), .battery_load_enable(battery_load_enable),
  .battery_load(battery_load));

// *** clock_core_model.sv ***
// model of the clock generator and converter core
`timescale 1ns/1ps
module clock_core_model
  import adc_seq_pkg::*;
(
  input  wire logic        clock,         // clock
  input  wire logic        rst_n,         // reset
  input  wire logic        slow,          // long start-up
  input  wire logic        clock_request, // request in
  input  wire logic        conv_start,    // start in
  input  wire logic [3:0]  conv_channel,  // mux channel
  output logic             clock_ack,     // grant
  output logic      [11:0] conv_data,     // result
  output logic             conv_over      // above reference
);
  logic [4:0] wake_r; // start-up count
  // oscillator starts on request, fast or after 20 cycles
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wake_r <= 5'h00;
      clock_ack <= 1'b0;
    end else begin
      wake_r <= clock_request ? wake_r + {4'h0, wake_r != 5'h1f} : 5'h00;
      clock_ack <= clock_request && (!slow || wake_r >= 5'h14);
    end
  end
  // result carries the channel; divider channel is over range
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      conv_data <= 12'h000;
      conv_over <= 1'b0;
    end else if (conv_start) begin
      conv_data <= {conv_channel, 8'h5a};
      conv_over <= (conv_channel == CH_DIVIDER);
    end
  end
endmodule

// *** sar_adc_sequencer_bench.sv ***
// bench: register access, scans in three precisions, queue drain
`timescale 1ns/1ps
module sar_adc_sequencer_bench
  import adc_seq_pkg::*;
;
  logic        clock, rst_n, read, write, trigger_in, dma_ack, slow, battery_load_enable;
  logic        waitrequest, clock_ack, conv_over, clock_request, conv_start, divider_enable;
  logic        battery_load, dma_request;
  logic [7:0]  address;
  logic [31:0] writedata, readdata, rd;
  logic [11:0] conv_data;
  logic [3:0]  conv_channel;
  logic [1:0]  clock_source_select, conv_precision;
  int          fails, n_checks, cyc, t0;
  logic [6:0]  base [3] = '{BASE_12, BASE_10, BASE_8}; // latency per precision
  logic [11:0] fs [3] = '{FS_12, FS_10, FS_8};         // full scale per precision
  sar_adc_sequencer u_sar_adc_sequencer (.clock(clock), .rst_n(rst_n), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .trigger_in(trigger_in), .clock_ack(clock_ack),
    .conv_data(conv_data), .conv_over(conv_over), .battery_load_enable(battery_load_enable),
    .dma_ack(dma_ack), .clock_request(clock_request), .clock_source_select(clock_source_select),
    .conv_start(conv_start), .conv_channel(conv_channel), .conv_precision(conv_precision),
    .divider_enable(divider_enable), .battery_load(battery_load), .dma_request(dma_request));
  clock_core_model u_clock_core_model (.clock(clock), .rst_n(rst_n), .slow(slow),
    .clock_request(clock_request), .conv_start(conv_start), .conv_channel(conv_channel),
    .clock_ack(clock_ack), .conv_data(conv_data), .conv_over(conv_over));
  task automatic cmp(input string what, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // bus write: hold until wait seen low
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    address <= a;
    writedata <= d;
    write <= 1'b1;
    do @(posedge clock); while (waitrequest);
    write <= 1'b0;
  endtask
  // bus read: data taken at the answering edge
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    address <= a;
    read <= 1'b1;
    do @(posedge clock); while (waitrequest);
    d = readdata;
    read <= 1'b0;
  endtask
  task automatic wait_start;
    do @(posedge clock); while (conv_start !== 1'b1);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // hang guard
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      conclude();
    end
  end
  initial begin
    {read, write, trigger_in, dma_ack, slow, battery_load_enable, rst_n} = '0;
    address = 8'h00;
    writedata = 32'h0;
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    bus_rd(OFF_CFG, rd);
    cmp("cfg", rd, {23'h0, CFG_RESET});
    cmp("clock_source_select", {30'h0, clock_source_select}, {30'h0, CLK_FAST_48});
    bus_rd(8'h18, rd);
    cmp("unmapped", rd, 32'h0);
    // slot 0 on pin 3, slot 1 on divider, tracking field 0x20
    bus_wr(OFF_SLOT_BASE, 32'h407);
    bus_wr(OFF_SLOT_BASE + 8'h04, 32'h41f);
    bus_rd(OFF_SLOT_BASE, rd);
    cmp("slot0", rd, 32'h407);
    for (int p = 0; p < 3; p++) begin
      slow <= p[0];
      bus_wr(OFF_CFG, {23'h0, p[1], p[1:0], 3'b010, CLK_FAST_24, 1'b1});
      bus_wr(OFF_TRIGGER, 32'h1);
      cmp("clock_source_select", {30'h0, clock_source_select}, {30'h0, CLK_FAST_24});
      wait_start();
      t0 = cyc;
      cmp("chan0", {28'h0, conv_channel}, 32'h3);
      wait_start();
      cmp("gap", cyc - t0, 37 + base[p] + 1);
      cmp("chan1", {28'h0, conv_channel}, {28'h0, CH_DIVIDER});
      cmp("div", {31'h0, divider_enable}, 32'h1);
      cmp("prec", {30'h0, conv_precision}, p);
      do @(posedge clock); while (clock_request);
      @(posedge clock);
      cmp("div off", {31'h0, divider_enable}, 32'h0);
      bus_rd(OFF_FLAGS, rd);
      cmp("flags", rd, 32'hc);
      bus_wr(OFF_FLAGS, 32'h7f);
      bus_rd(OFF_FLAGS, rd);
      cmp("flags clr", rd, 32'h0);
      bus_rd(OFF_STATUS, rd);
      cmp("count", {27'h0, rd[4:0]}, 32'h2);
      cmp("dreq", {31'h0, dma_request}, {31'h0, p[1]});
      bus_rd(OFF_FIFO, rd);
      cmp("entry0", rd, {11'h0, 5'd2, 4'h0, 12'h35a & fs[p]});
      bus_rd(OFF_FIFO, rd);
      cmp("entry1", rd, {11'h0, 5'd1, 4'h1, fs[p]});
    end
    bus_rd(OFF_STATUS, rd);
    cmp("empty", {27'h0, rd[4:0]}, 32'h0);
    bus_wr(OFF_CFG, 32'hd);
    repeat (4) @(posedge clock);
    cmp("keep", {31'h0, clock_request}, 32'h1);
    battery_load_enable <= 1'b1;
    repeat (2) @(posedge clock);
    cmp("load", {31'h0, battery_load}, 32'h1);
    conclude();
  end
endmodule
